// >>> src/odt_ctrl_pkg.sv
// Shared constants and types for the on-die termination control block
package odt_ctrl_pkg;

    // Mode-register addressing
    localparam int unsigned MR_ADDR_W = 6;
    localparam int unsigned MR_DATA_W = 8;
    localparam logic [5:0]  TERM_VALUE_SELECT_ADDR   = 6'h0B;  // Termination value select
    localparam logic [5:0]  CA_TERM_OPTIONS_ADDR     = 6'h16;  // Command/address options

    // Reset values: every termination disabled
    localparam logic [7:0]  TERM_VALUE_SELECT_RESET  = 8'h00;
    localparam logic [7:0]  CA_TERM_OPTIONS_RESET    = 8'h00;

    // Field positions in termination_value_select
    localparam int unsigned DQ_CODE_LSB = 0;
    localparam int unsigned CA_CODE_LSB = 4;
    localparam int unsigned CODE_W      = 3;

    // Bit positions in ca_termination_options
    localparam int unsigned CLK_TERM_OFF_BIT    = 3;
    localparam int unsigned CS_TERM_OFF_BIT     = 4;
    localparam int unsigned CA_TERM_DISABLE_BIT = 5;

    // Resistance codes
    localparam logic [2:0] CODE_OFF    = 3'h0;
    localparam logic [2:0] CODE_240    = 3'h1;
    localparam logic [2:0] CODE_40     = 3'h6;

    // Write burst duration on the clock, in clock cycles (two beats per clock)
    localparam int unsigned BL16_CYCLES = 8;
    localparam int unsigned BL32_CYCLES = 16;
    localparam int unsigned CNT_W       = 7;

    // Termination switch states driven toward the pads
    typedef struct packed {
        logic ca;   // CA[5:0] lines
        logic clk;  // Differential clock pair
        logic cs;   // Chip select
        logic dq;   // Data lines
        logic dqs;  // Strobe pair
        logic dmi;  // Data mask / inversion line
    } term_state_t;

    // Mode-register write request
    typedef struct packed {
        logic                 valid;
        logic [MR_ADDR_W-1:0] addr;
        logic [MR_DATA_W-1:0] data;
    } mrw_req_t;

    // Decode a resistance code as one that selects 240 down to 40 ohm
    function automatic logic code_valid(input logic [2:0] code);
        code_valid = (code >= CODE_240) && (code <= CODE_40);
    endfunction : code_valid

endpackage : odt_ctrl_pkg

// >>> src/on_die_termination_control.sv
// On-die termination control for command/address and data groups
//
// Operation
// - Command/address resistance comes from three-bit field; 001..110 select 240..40 ohm.
// - After reset command/address termination stays off until a valid code is written.
// - Disabled field turns all off; else per-group off bits for CA, clock, select.
// - Command/address termination is unchanged when entering power-down.
// - Covers clock pair, chip select, six CA lines; controlled only by registers.
// - Data termination is off during power-down or self-refresh.
// - Data termination switch reacts to write commands, qualified by register settings.
// - Data termination mode enabled for nonzero field, disabled for zero.
// - Data termination covers each DQ line, both strobes, mask/inversion line.
// - Data field codes 001..110 select 240..40 ohm; unlike command/address, 111 also enables data termination.
// - Data group high-impedance except during a write; off when burst completes.
// - Write leveling: strobes terminated when enabled, DQ always off.
`timescale 1ns/1ns
module on_die_termination_control #(
    parameter int unsigned WRITE_LAT = 8    // Clocks from write command to first data
) (
    input  wire logic                        sys_clk_i,       // Command clock, 100 MHz
    input  wire logic                        sys_rst_i,       // Async reset, active high
    input  wire odt_ctrl_pkg::mrw_req_t      mrw_i,           // Mode-register write
    input  wire logic [odt_ctrl_pkg::MR_ADDR_W-1:0] mrr_addr_i, // Mode-register read address
    output logic [odt_ctrl_pkg::MR_DATA_W-1:0]      mrr_data_o, // Mode-register read data
    input  wire logic                        write_cmd_i,     // Sampled write or masked write
    input  wire logic                        burst32_i,       // Burst of 32 beats
    input  wire logic                        power_down_i,    // Device in power-down
    input  wire logic                        self_refresh_i,  // Device in self-refresh
    input  wire logic                        write_level_i,   // Write leveling mode active
    output odt_ctrl_pkg::term_state_t        term_o,          // Termination switches
    output logic [2:0]                       ca_code_o,       // Command/address resistance
    output logic [2:0]                       dq_code_o        // Data resistance code
);

    // Mode registers
    logic [7:0] value_select;
    logic [7:0] ca_options;

    // Write burst window counter
    logic [odt_ctrl_pkg::CNT_W-1:0] window_cnt;
    logic [odt_ctrl_pkg::CNT_W-1:0] next_window_cnt;

    // Registered outputs
    odt_ctrl_pkg::term_state_t next_term;
    logic [7:0]                next_mrr_data;

    // Field decode
    wire logic [2:0] ca_code_field =
        value_select[odt_ctrl_pkg::CA_CODE_LSB +: odt_ctrl_pkg::CODE_W];
    wire logic [2:0] dq_code_field =
        value_select[odt_ctrl_pkg::DQ_CODE_LSB +: odt_ctrl_pkg::CODE_W];
    wire logic ca_enabled  = odt_ctrl_pkg::code_valid(ca_code_field);
    wire logic dq_enabled  = (dq_code_field != odt_ctrl_pkg::CODE_OFF);
    wire logic ca_off      = ca_options[odt_ctrl_pkg::CA_TERM_DISABLE_BIT];
    wire logic clk_off     = ca_options[odt_ctrl_pkg::CLK_TERM_OFF_BIT];
    wire logic cs_off      = ca_options[odt_ctrl_pkg::CS_TERM_OFF_BIT];
    wire logic low_power   = power_down_i | self_refresh_i;

    // Match a bus address against the address of one mode register
    function automatic logic addr_is(
        input logic [odt_ctrl_pkg::MR_ADDR_W-1:0] addr,
        input logic [odt_ctrl_pkg::MR_ADDR_W-1:0] reg_addr
    );
        addr_is = (addr == reg_addr);
    endfunction : addr_is

    // Register write decode; writes to any other address are dropped
    wire logic wr_value    = mrw_i.valid &&
        addr_is(mrw_i.addr, odt_ctrl_pkg::TERM_VALUE_SELECT_ADDR);
    wire logic wr_options  = mrw_i.valid &&
        addr_is(mrw_i.addr, odt_ctrl_pkg::CA_TERM_OPTIONS_ADDR);

    // Read-back decode
    wire logic rd_value    = addr_is(mrr_addr_i, odt_ctrl_pkg::TERM_VALUE_SELECT_ADDR);
    wire logic rd_options  = addr_is(mrr_addr_i, odt_ctrl_pkg::CA_TERM_OPTIONS_ADDR);

    // Write burst window: latency plus burst length, restarted by every accepted write
    wire logic [odt_ctrl_pkg::CNT_W-1:0] burst_cycles = burst32_i ?
        odt_ctrl_pkg::CNT_W'(odt_ctrl_pkg::BL32_CYCLES) :
        odt_ctrl_pkg::CNT_W'(odt_ctrl_pkg::BL16_CYCLES);
    wire logic [odt_ctrl_pkg::CNT_W-1:0] window_len =
        odt_ctrl_pkg::CNT_W'(WRITE_LAT) + burst_cycles;
    wire logic write_taken = write_cmd_i && dq_enabled && !low_power && !write_level_i;

    // Counter next value
    always_comb
    begin
        if (write_taken)
            next_window_cnt = window_len;
        else if (low_power)
            next_window_cnt = '0;
        else if (window_cnt != '0)
            next_window_cnt = window_cnt - odt_ctrl_pkg::CNT_W'(1);
        else
            next_window_cnt = '0;
    end

    // Termination switch decode
    always_comb
    begin
        next_term.ca  = ca_enabled && !ca_off;
        next_term.clk = ca_enabled && !clk_off;
        next_term.cs  = ca_enabled && !cs_off;
        if (write_level_i)
        begin
            next_term.dq  = 1'b0;
            next_term.dqs = dq_enabled && !low_power;
            next_term.dmi = 1'b0;
        end
        else
        begin
            next_term.dq  = dq_enabled && !low_power && (next_window_cnt != '0);
            next_term.dqs = next_term.dq;
            next_term.dmi = next_term.dq;
        end
    end

    // Read-back select
    always_comb
    begin
        if (rd_value)
            next_mrr_data = value_select;
        else if (rd_options)
            next_mrr_data = ca_options;
        else
            next_mrr_data = '0;
    end

    // Mode registers
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            value_select <= odt_ctrl_pkg::TERM_VALUE_SELECT_RESET;
            ca_options   <= odt_ctrl_pkg::CA_TERM_OPTIONS_RESET;
        end
        else
        begin
            if (wr_value)
                value_select <= mrw_i.data;
            if (wr_options)
                ca_options <= mrw_i.data;
        end
    end

    // Window counter and outputs
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            window_cnt <= '0;
            term_o     <= '0;
            ca_code_o  <= odt_ctrl_pkg::CODE_OFF;
            dq_code_o  <= odt_ctrl_pkg::CODE_OFF;
            mrr_data_o <= '0;
        end
        else
        begin
            window_cnt <= next_window_cnt;
            term_o     <= next_term;
            ca_code_o  <= ca_enabled ? ca_code_field : odt_ctrl_pkg::CODE_OFF;
            dq_code_o  <= dq_code_field;
            mrr_data_o <= next_mrr_data;
        end
    end

    // Check helper: clocks since the last accepted write, and that write's burst
    logic [odt_ctrl_pkg::CNT_W-1:0] quiet_cnt;
    logic                           quiet_b32;
    wire logic [odt_ctrl_pkg::CNT_W-1:0] burst_end_cnt = quiet_b32 ?
        odt_ctrl_pkg::CNT_W'(WRITE_LAT) + odt_ctrl_pkg::CNT_W'(odt_ctrl_pkg::BL32_CYCLES) :
        odt_ctrl_pkg::CNT_W'(WRITE_LAT) + odt_ctrl_pkg::CNT_W'(odt_ctrl_pkg::BL16_CYCLES);

    // Saturates at all ones, so no burst end is expected before the first write
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            quiet_cnt <= '1;
            quiet_b32 <= 1'b0;
        end
        else if (write_taken)
        begin
            quiet_cnt <= '0;
            quiet_b32 <= burst32_i;
        end
        else if (quiet_cnt != '1)
            quiet_cnt <= quiet_cnt + odt_ctrl_pkg::CNT_W'(1);
    end

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_ca_code_map: assert property (
        ca_code_o != odt_ctrl_pkg::CODE_OFF |->
        (ca_code_o >= odt_ctrl_pkg::CODE_240 && ca_code_o <= odt_ctrl_pkg::CODE_40))
        else $error("Command/address code out of range");

    a_ca_reset_off: assert property (
        $fell(sys_rst_i) |-> !term_o.ca && !term_o.clk && !term_o.cs)
        else $error("Command/address termination on after reset");

    a_ca_group_off: assert property (
        !ca_enabled |=> !term_o.ca && !term_o.clk && !term_o.cs)
        else $error("Group termination on while field disabled");

    a_ca_option_bits: assert property (
        ca_enabled |=> term_o.ca == !$past(ca_off) && term_o.clk == !$past(clk_off)
                       && term_o.cs == !$past(cs_off))
        else $error("Option bit did not steer its group");

    a_ca_pd_hold: assert property (
        $rose(power_down_i) && $stable(value_select) && $stable(ca_options)
        |=> $stable(term_o.ca) && $stable(term_o.clk) && $stable(term_o.cs))
        else $error("Command/address termination changed at power-down");

    a_dq_low_power: assert property (
        low_power |=> !term_o.dq && !term_o.dqs && !term_o.dmi)
        else $error("Data termination on in low-power state");

    a_dq_disabled: assert property (
        !dq_enabled |=> !term_o.dq && !term_o.dqs && !term_o.dmi)
        else $error("Data termination on while mode disabled");

    a_dq_write_on: assert property (
        write_taken |=> term_o.dq && term_o.dqs && term_o.dmi)
        else $error("Write did not turn data termination on");

    a_dq_burst_end: assert property (
        quiet_cnt == burst_end_cnt |-> !term_o.dq && !term_o.dmi)
        else $error("Data termination stayed on past the burst");

    a_dq_burst_span: assert property (
        write_taken ##1 (dq_enabled && !low_power && !write_level_i)[*7]
        |=> term_o.dq && term_o.dqs && term_o.dmi)
        else $error("Data termination dropped inside the burst");

    a_dq_idle_off: assert property (
        window_cnt == '0 && !write_taken && !write_level_i |=> !term_o.dq)
        else $error("Data termination on outside a write");

    a_wl_strobe: assert property (
        write_level_i && !low_power |=> !term_o.dq && term_o.dqs == $past(dq_enabled))
        else $error("Write leveling termination wrong");

    a_dq_code_map: assert property (
        1'b1 |=> dq_code_o == $past(dq_code_field))
        else $error("Data code not carried to output");

    a_ca_code_pass: assert property (
        ca_enabled |=> ca_code_o == $past(ca_code_field))
        else $error("Command/address code not carried to output");

    a_ca_code_off: assert property (
        !ca_enabled |=> ca_code_o == odt_ctrl_pkg::CODE_OFF)
        else $error("Command/address code shown while disabled");

    a_dq_pd_clear: assert property (
        low_power |=> window_cnt == '0)
        else $error("Write window survived a low-power state");

    a_dq_group_same: assert property (
        !write_level_i |=> term_o.dqs == term_o.dq && term_o.dmi == term_o.dq)
        else $error("Data group lines not switched together");

    a_wl_mask_off: assert property (
        write_level_i |=> !term_o.dmi)
        else $error("Mask line terminated in write leveling");

    // Register bus checks
    a_mr_value_lands: assert property (
        wr_value |=> value_select == $past(mrw_i.data))
        else $error("Value select write did not land");

    a_mr_option_lands: assert property (
        wr_options |=> ca_options == $past(mrw_i.data))
        else $error("Option write did not land");

    a_mr_other_addr: assert property (
        mrw_i.valid && !wr_value && !wr_options
        |=> $stable(value_select) && $stable(ca_options))
        else $error("Write to another address changed a register");

    a_rd_value: assert property (
        rd_value |=> mrr_data_o == $past(value_select))
        else $error("Value select read back wrong");

    a_rd_options: assert property (
        rd_options |=> mrr_data_o == $past(ca_options))
        else $error("Option register read back wrong");

    a_rd_other: assert property (
        !rd_value && !rd_options |=> mrr_data_o == '0)
        else $error("Read of another address not zero");

    // Main scenarios
    c_write_burst:   cover property (write_taken ##1 term_o.dq [*3]);
    c_ca_partial:    cover property (term_o.ca && !term_o.cs);
    c_write_level:   cover property (write_level_i && term_o.dqs);
    c_pd_with_ca:    cover property (power_down_i && term_o.ca);
    c_burst_restart: cover property (write_taken && window_cnt != '0);

endmodule : on_die_termination_control

// >>> test/odt_ctrl_host_model.sv
// Controller model that writes mode registers and issues write commands
`timescale 1ns/1ns
module odt_ctrl_host_model #(
    parameter int unsigned UPDATE_CYCLES = 4  // Deselect span after a register write
) (
    input  wire logic                   sys_clk_i,  // Command clock
    output odt_ctrl_pkg::mrw_req_t      mrw_o,      // Mode-register write
    output logic                        write_o,    // Write command pulse
    output logic                        burst32_o   // Burst length select
);
    // Idle command bus at time zero
    initial
    begin
        mrw_o     = '0;
        write_o   = 1'b0;
        burst32_o = 1'b0;
    end

    // One register write, then the bus stays deselected while the setting settles
    task automatic mr_write(input logic [5:0] addr, input logic [7:0] data);
        @(posedge sys_clk_i);
        #1 mrw_o <= {1'b1, addr, data};
        @(posedge sys_clk_i);
        #1 mrw_o <= {1'b0, ~addr, ~data};  // Released lines do not keep the old value
        repeat (UPDATE_CYCLES) @(posedge sys_clk_i);
    endtask : mr_write

    // One write command with its burst length
    task automatic wr(input logic b32);
        @(posedge sys_clk_i);
        #1 write_o <= 1'b1;
        burst32_o <= b32;
        @(posedge sys_clk_i);
        #1 write_o <= 1'b0;
        burst32_o <= ~b32;
    endtask : wr
endmodule : odt_ctrl_host_model

// >>> test/on_die_termination_control_tb.sv
// Self-checking bench for the on-die termination control block
`timescale 1ns/1ns
module on_die_termination_control_tb;
    localparam int unsigned WL = 8;
    localparam logic [5:0]  VS = odt_ctrl_pkg::TERM_VALUE_SELECT_ADDR;
    localparam logic [5:0]  CO = odt_ctrl_pkg::CA_TERM_OPTIONS_ADDR;
    logic                       sys_clk_i;
    logic                       sys_rst_i;
    logic                       power_down_i;
    logic                       self_refresh_i;
    logic                       write_level_i;
    logic                       write_cmd;
    logic                       burst32;
    logic                       ok;
    logic [5:0]                 mrr_addr;
    logic [7:0]                 mrr_data;
    logic [2:0]                 ca_code;
    logic [2:0]                 dq_code;
    odt_ctrl_pkg::mrw_req_t     mrw;
    odt_ctrl_pkg::term_state_t  term;
    int                         n_errors = 0;
    int                         n_compared = 0;

    on_die_termination_control #(.WRITE_LAT(WL)) on_die_termination_control_i (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .mrw_i(mrw), .mrr_addr_i(mrr_addr),
        .mrr_data_o(mrr_data), .write_cmd_i(write_cmd), .burst32_i(burst32),
        .power_down_i(power_down_i), .self_refresh_i(self_refresh_i),
        .write_level_i(write_level_i), .term_o(term), .ca_code_o(ca_code), .dq_code_o(dq_code));

    odt_ctrl_host_model odt_ctrl_host_model_i (
        .sys_clk_i(sys_clk_i), .mrw_o(mrw), .write_o(write_cmd), .burst32_o(burst32));

    // Compare one value and count it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Register read: address one cycle ahead of the data
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        #1 mrr_addr <= a;
        @(posedge sys_clk_i);
        #2 chk(mrr_data, exp);
    endtask : rd

    // Write command, then the termination window at its first edge, its last edge and one edge after
    task automatic win(input logic b32, input logic [5:0] e);
        odt_ctrl_host_model_i.wr(b32);
        #1 chk({2'h0, term}, {2'h0, e});
        repeat (WL + (b32 ? 15 : 7)) @(posedge sys_clk_i);
        #2 chk({2'h0, term}, {2'h0, e});
        @(posedge sys_clk_i);
        #2 chk({2'h0, term}, 8'h38);
    endtask : win

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // Free-running command clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Hang guard
    initial
    begin
        #100000;
        n_errors++;
        report_and_stop();
    end

    // Test sequence
    initial
    begin
        sys_rst_i = 1'b1;
        power_down_i = 1'b0;
        self_refresh_i = 1'b0;
        write_level_i = 1'b0;
        mrr_addr = 6'h00;
        repeat (10) @(posedge sys_clk_i);
        #1 sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
        #2 chk({2'h0, term}, 8'h00);
        rd(VS, odt_ctrl_pkg::TERM_VALUE_SELECT_RESET);
        rd(CO, odt_ctrl_pkg::CA_TERM_OPTIONS_RESET);
        for (int c = 0; c < 8; c++)
        begin
            odt_ctrl_host_model_i.mr_write(VS, {1'b0, 3'(c), 4'h0});
            ok = (c >= 1) && (c <= 6);
            #2 chk({5'h00, ca_code}, ok ? 8'(c) : 8'h00);
            chk({2'h0, term}, {2'h0, ok, ok, ok, 3'h0});
            rd(VS, {1'b0, 3'(c), 4'h0});
        end
        odt_ctrl_host_model_i.mr_write(VS, 8'h20);
        for (int o = 0; o < 8; o++)
        begin
            odt_ctrl_host_model_i.mr_write(CO, {2'h0, 3'(o), 3'h0});
            #2 chk({2'h0, term}, {2'h0, ~o[2], ~o[0], ~o[1], 3'h0});
        end
        odt_ctrl_host_model_i.mr_write(CO, 8'h00);
        odt_ctrl_host_model_i.mr_write(6'h3F, 8'hA5);
        rd(6'h3F, 8'h00);
        @(posedge sys_clk_i);
        #1 power_down_i <= 1'b1;
        odt_ctrl_host_model_i.mr_write(VS, 8'h23);
        odt_ctrl_host_model_i.wr(1'b0);
        #1 chk({2'h0, term}, 8'h38);
        @(posedge sys_clk_i);
        #1 power_down_i <= 1'b0;
        for (int c = 0; c < 8; c++)
        begin
            odt_ctrl_host_model_i.mr_write(VS, {5'h04, 3'(c)});
            #2 chk({5'h00, dq_code}, 8'(c));
            win(c[0], (c != 0) ? 6'h3F : 6'h38);
        end
        odt_ctrl_host_model_i.wr(1'b0);
        repeat (4) @(posedge sys_clk_i);
        win(1'b0, 6'h3F);
        odt_ctrl_host_model_i.wr(1'b1);
        @(posedge sys_clk_i);
        #1 self_refresh_i <= 1'b1;
        @(posedge sys_clk_i);
        #2 chk({2'h0, term}, 8'h38);
        @(posedge sys_clk_i);
        #1 self_refresh_i <= 1'b0;
        write_level_i <= 1'b1;
        @(posedge sys_clk_i);
        #2 chk({2'h0, term}, 8'h3A);
        odt_ctrl_host_model_i.mr_write(VS, 8'h20);
        #2 chk({2'h0, term}, 8'h38);
        // Reset again in mid-run: registers and switches return to off
        @(posedge sys_clk_i);
        #1 write_level_i <= 1'b0;
        sys_rst_i <= 1'b1;
        @(posedge sys_clk_i);
        #1 sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
        #2 chk({2'h0, term}, 8'h00);
        chk({5'h00, ca_code}, 8'h00);
        rd(VS, odt_ctrl_pkg::TERM_VALUE_SELECT_RESET);
        report_and_stop();
    end
endmodule : on_die_termination_control_tb
